/* adc_cfg.svh */
// constants for the converter control block
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH
`define RESULT_WIDTH      10
`define PAIR_WIDTH        16
`define BIT_PERIOD_CYCLES 8'h08
`define ACQ_CYCLES        8'h10
`define CONV_BITS         4'hB
`define LOW_BYTE_RESET    8'h00
`define HIGH_BYTE_RESET   8'h00
`endif

/* adc_pkg.sv */
// types shared by the converter control block
`default_nettype none
package adc_pkg;
  typedef enum logic [1:0] {
    ST_OFF     = 2'b00,
    ST_ACQUIRE = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_t;
endpackage : adc_pkg
`default_nettype wire

/* bit_period_gen.sv */
// conversion bit period tick generator
`timescale 1ns/100ps
`default_nettype none
`include "adc_cfg.svh"
module bit_period_gen (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       restart_in,
  output var  logic       tick_out
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic       next_tick;

  always_comb begin
    next_count = count + 8'h01;
    next_tick  = 1'b0;
    if (restart_in) begin
      next_count = 8'h00;
    end else if (count == `BIT_PERIOD_CYCLES - 8'h01) begin
      next_count = 8'h00;
      next_tick  = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count    <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      count    <= next_count;
      tick_out <= next_tick;
    end
  end
endmodule : bit_period_gen
`default_nettype wire

/* adc_conversion_control.sv */
// conversion control, result pair and go flag sequencing
`timescale 1ns/100ps
`default_nettype none
`include "adc_cfg.svh"
// Functional notes
// - clearing go mid-conversion aborts at once
// - abort leaves both result bytes unchanged
// - abort restarts acquisition, count from zero
// - setting go again starts new conversion
// - first segment one bit period plus one clock
// - completion loads result into sixteen-bit pair
// - format bit selects left or right justify
// - unused six bits loaded as zeros
// - disabled converter: bytes are plain storage
module adc_conversion_control (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       converter_on_in,
  input  wire logic       result_format_select_in,
  input  wire logic       go_set_in,
  input  wire logic       go_clear_in,
  input  wire logic       done_flag_clear_in,
  input  wire logic       low_byte_write_in,
  input  wire logic       high_byte_write_in,
  input  wire logic [7:0] write_data_in,
  input  wire logic       comparator_in,
  output var  logic       go_flag_out,
  output var  logic       conversion_done_flag_out,
  output var  logic       acquiring_out,
  output var  logic       sample_hold_out,
  output var  logic [9:0] sar_trial_out,
  output var  logic [7:0] result_high_byte_out,
  output var  logic [7:0] result_low_byte_out
);
  // ==========================================================
  // input synchroniser for the comparator pin
  logic comp_meta;
  logic comp_sync;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      comp_meta <= comparator_in;
      comp_sync <= comp_meta;
    end
  end

  // ==========================================================
  // bit period timing
  logic bit_tick;
  logic restart_timer;

  bit_period_gen u_bit_period (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .restart_in (restart_timer),
    .tick_out   (bit_tick)
  );

  // ==========================================================
  // justification of a finished result
  function automatic logic [15:0] justify(input logic [9:0] value,
                                          input logic       right);
    if (right) begin
      justify = {6'h00, value};
    end else begin
      justify = {value, 6'h00};
    end
  endfunction : justify

  // ==========================================================
  // one approximation step: settle the bit on trial,
  // then raise the next lower bit as the new trial
  function automatic logic [9:0] sar_step(input logic [9:0] trial,
                                          input logic [3:0] index,
                                          input logic       keep);
    logic [9:0] step;
    step = trial;
    if (!keep) begin
      step[index - 4'h1] = 1'b0;
    end
    if (index > 4'h1) begin
      step[index - 4'h2] = 1'b1;
    end
    sar_step = step;
  endfunction : sar_step

  // ==========================================================
  // conversion sequencer
  adc_pkg::conv_state_t state;
  adc_pkg::conv_state_t next_state;
  logic [7:0]           acq_count;
  logic [7:0]           next_acq_count;
  logic [3:0]           bit_index;
  logic [3:0]           next_bit_index;
  logic [9:0]           sar;
  logic [9:0]           next_sar;
  logic                 next_go;
  logic                 next_done;
  logic [7:0]           next_high;
  logic [7:0]           next_low;
  logic [15:0]          loaded;
  logic                 go_rise;
  logic                 finish;

  assign go_rise = go_set_in && !go_flag_out;

  always_comb begin
    next_state     = state;
    next_acq_count = acq_count;
    next_bit_index = bit_index;
    next_sar       = sar;
    next_go        = go_flag_out;
    next_done      = conversion_done_flag_out;
    next_high      = result_high_byte_out;
    next_low       = result_low_byte_out;
    restart_timer  = 1'b0;
    finish         = 1'b0;
    loaded         = justify(sar, result_format_select_in);
    if (done_flag_clear_in) begin
      next_done = 1'b0;
    end
    // software stores; completion below overrides
    if (low_byte_write_in) begin
      next_low = write_data_in;
    end
    if (high_byte_write_in) begin
      next_high = write_data_in;
    end
    if (go_clear_in) begin
      next_go = 1'b0;
    end
    if (go_set_in && converter_on_in) begin
      next_go = 1'b1;
    end
    case (state)
      adc_pkg::ST_OFF: begin
        next_go = 1'b0;
        if (converter_on_in) begin
          next_state     = adc_pkg::ST_ACQUIRE;
          next_acq_count = 8'h00;
        end
      end
      adc_pkg::ST_ACQUIRE: begin
        if (acq_count != `ACQ_CYCLES) begin
          next_acq_count = acq_count + 8'h01;
        end
        if (go_rise) begin
          // timer restarts: first segment is one bit period plus one clock
          restart_timer  = 1'b1;
          next_state     = adc_pkg::ST_CONVERT;
          next_bit_index = `CONV_BITS;
          next_sar       = 10'h200;
        end
      end
      adc_pkg::ST_CONVERT: begin
        // a same-cycle set wins, so no abort then
        if (go_clear_in && !go_set_in) begin
          // abort: result bytes untouched, reacquire
          next_state     = adc_pkg::ST_ACQUIRE;
          next_acq_count = 8'h00;
          next_sar       = 10'h000;
        end else if (bit_tick && converter_on_in) begin
          // no completion once the converter is switched off
          if (bit_index == 4'h0) begin
            finish         = 1'b1;
            next_state     = adc_pkg::ST_ACQUIRE;
            next_acq_count = 8'h00;
            next_go        = 1'b0;
            next_done      = 1'b1;
            next_high      = loaded[15:8];
            next_low       = loaded[7:0];
          end else begin
            next_bit_index = bit_index - 4'h1;
            // first period only samples, ten trials follow
            if (bit_index <= 4'hA) begin
              next_sar = sar_step(sar, bit_index, comp_sync);
            end
          end
        end
      end
      default: begin
        next_state = adc_pkg::ST_OFF;
      end
    endcase
    if (!converter_on_in) begin
      next_state = adc_pkg::ST_OFF;
      next_go    = 1'b0;
    end
  end

  // ==========================================================
  // register stage of the sequencer and outputs
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state                    <= adc_pkg::ST_OFF;
      acq_count                <= 8'h00;
      bit_index                <= 4'h0;
      sar                      <= 10'h000;
      go_flag_out              <= 1'b0;
      conversion_done_flag_out <= 1'b0;
      result_high_byte_out     <= `HIGH_BYTE_RESET;
      result_low_byte_out      <= `LOW_BYTE_RESET;
      acquiring_out            <= 1'b0;
      sample_hold_out          <= 1'b0;
      sar_trial_out            <= 10'h000;
    end else begin
      state                    <= next_state;
      acq_count                <= next_acq_count;
      bit_index                <= next_bit_index;
      sar                      <= next_sar;
      go_flag_out              <= next_go;
      conversion_done_flag_out <= next_done;
      result_high_byte_out     <= next_high;
      result_low_byte_out      <= next_low;
      acquiring_out            <= (next_state == adc_pkg::ST_ACQUIRE);
      sample_hold_out          <= (next_state == adc_pkg::ST_CONVERT);
      sar_trial_out            <= next_sar;
    end
  end
endmodule : adc_conversion_control
`default_nettype wire

/* adc_chk.sv */
// assertion checker for the conversion control block
`timescale 1ns/100ps
`default_nettype none
module adc_chk (
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic       converter_on_in,
  input wire logic       result_format_select_in,
  input wire logic       go_set_in,
  input wire logic       go_clear_in,
  input wire logic       done_flag_clear_in,
  input wire logic       low_byte_write_in,
  input wire logic       high_byte_write_in,
  input wire logic [7:0] write_data_in,
  input wire logic       go_flag_out,
  input wire logic       conversion_done_flag_out,
  input wire logic       acquiring_out,
  input wire logic       sample_hold_out,
  input wire logic [7:0] result_high_byte_out,
  input wire logic [7:0] result_low_byte_out
);
  // ==========
  // properties
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  go_rise_a: assert property (converter_on_in && go_set_in && !go_flag_out
    |=> go_flag_out) else $error("go not set");
  go_hold_a: assert property (!go_flag_out && !go_set_in |=> !go_flag_out)
    else $error("go rose alone");
  go_refuse_a: assert property (!converter_on_in && !go_flag_out |=>
    !go_flag_out) else $error("go set while off");
  abort_stop_a: assert property (go_flag_out && go_clear_in && !go_set_in
    |=> !go_flag_out && acquiring_out && !sample_hold_out)
    else $error("abort missed");
  abort_keep_a: assert property (go_flag_out && go_clear_in && !go_set_in
    && !low_byte_write_in && !high_byte_write_in |=>
    $stable({result_high_byte_out, result_low_byte_out}))
    else $error("abort changed bytes");
  done_set_a: assert property (go_flag_out && !go_clear_in && converter_on_in
    ##1 !go_flag_out |-> conversion_done_flag_out && acquiring_out)
    else $error("done not set");
  zero_fill_a: assert property (go_flag_out && !go_clear_in ##1 !go_flag_out
    |-> (result_format_select_in ? result_high_byte_out[7:2] == 6'h00
    : result_low_byte_out[5:0] == 6'h00)) else $error("fill not zero");
  done_keep_a: assert property (conversion_done_flag_out &&
    !done_flag_clear_in |=> conversion_done_flag_out)
    else $error("done lost");
  low_store_a: assert property (!converter_on_in && low_byte_write_in |=>
    result_low_byte_out == $past(write_data_in))
    else $error("low byte write");
  high_store_a: assert property (!converter_on_in && high_byte_write_in |=>
    result_high_byte_out == $past(write_data_in))
    else $error("high byte write");
endmodule : adc_chk
bind adc_conversion_control adc_chk i_adc_chk (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .converter_on_in(converter_on_in),
  .result_format_select_in(result_format_select_in),
  .go_set_in(go_set_in), .go_clear_in(go_clear_in),
  .done_flag_clear_in(done_flag_clear_in),
  .low_byte_write_in(low_byte_write_in),
  .high_byte_write_in(high_byte_write_in), .write_data_in(write_data_in),
  .go_flag_out(go_flag_out),
  .conversion_done_flag_out(conversion_done_flag_out),
  .acquiring_out(acquiring_out), .sample_hold_out(sample_hold_out),
  .result_high_byte_out(result_high_byte_out),
  .result_low_byte_out(result_low_byte_out));
`default_nettype wire

/* adc_conversion_control_test.sv */
// random self-checking bench for the conversion control block
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_control_test;
  logic        clk_in, rst_n_in, on, fmt, gs, gc, dc, lw, hw, cv;
  logic        go, done, acq, sh;
  logic [7:0]  wd, hb, lb;
  logic [9:0]  trial, vin;
  logic [31:0] rng;
  int          fail_count, cmp_count, n;
  adc_conversion_control i_adc_conversion_control (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .converter_on_in(on),
    .result_format_select_in(fmt), .go_set_in(gs), .go_clear_in(gc),
    .done_flag_clear_in(dc), .low_byte_write_in(lw),
    .high_byte_write_in(hw), .write_data_in(wd), .comparator_in(cv),
    .go_flag_out(go), .conversion_done_flag_out(done),
    .acquiring_out(acq), .sample_hold_out(sh), .sar_trial_out(trial),
    .result_high_byte_out(hb), .result_low_byte_out(lb));
  // ==========
  // clock, analog input model, helpers
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) cv <= vin >= trial;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [15:0] pair(input logic f, input logic [9:0] v);
    return f ? {6'h00, v} : {v, 6'h00};
  endfunction : pair
  task automatic chk(input string s, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic clk1;
    @(posedge clk_in);
  endtask : clk1
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic pulse_go;
    gs <= 1'b1;
    clk1;
    gs <= 1'b0;
    #1;
    chk("go", 16'h0001, {15'h0000, go});
  endtask : pulse_go
  task automatic run(input logic ab, input logic rf, input logic [9:0] v);
    logic [15:0] old;
    rng = xs(rng);
    vin <= v;
    fmt <= rf;
    clk1;
    pulse_go();
    old = {hb, lb};
    if (ab) begin
      repeat (40) clk1;
      gc <= 1'b1;
      clk1;
      gc <= 1'b0;
      #1;
      chk("abort bytes", old, {hb, lb});
      chk("abort state", 16'h0001, {14'h0000, go, acq});
      clk1;
      pulse_go();
    end
    n = 1;
    do begin
      clk1;
      #1;
      n++;
    end while (go === 1'b1 && n < 120);
    chk("latency", 16'h0001, {15'h0000, n >= 96 && n <= 98});
    chk("result", pair(fmt, vin), {hb, lb});
    chk("done", 16'h0003, {14'h0000, done, acq});
    clk1;
    dc <= 1'b1;
    clk1;
    dc <= 1'b0;
    #1;
    chk("done clear", 16'h0000, {15'h0000, done});
    $display("conversion test ended, abort %0d", ab);
    clk1;
  endtask : run
  // ==========
  // main sequence and watchdog
  initial begin
    {on, fmt, gs, gc, dc, lw, hw, rst_n_in} = 8'h00;
    {wd, vin, fail_count, cmp_count} = '0;
    rng = 32'h00001A2E;
    repeat (2) clk1;
    rst_n_in <= 1'b1;
    repeat (3) begin
      clk1;
      rng = xs(rng);
      wd <= rng[7:0];
      lw <= 1'b1;
      clk1;
      lw <= 1'b0;
      wd <= rng[15:8];
      hw <= 1'b1;
      clk1;
      hw <= 1'b0;
      gs <= 1'b1;
      clk1;
      gs <= 1'b0;
      #1;
      chk("go refused", 16'h0000, {15'h0000, go});
      chk("store", rng[15:0], {hb, lb});
    end
    $display("storage test ended");
    clk1;
    on <= 1'b1;
    repeat (4) clk1;
    run(1'b0, 1'b0, 10'h000);
    run(1'b1, 1'b1, 10'h3FF);
    repeat (4) run(rng[3], rng[10], rng[25:16]);
    end_sim();
  end
  initial begin
    #24000;
    fail_count++;
    end_sim();
  end
endmodule : adc_conversion_control_test
`default_nettype wire
